// ---- rtl/rpq_pkg.sv ----
/*
  Package for the reset pin qualifier: timing counts, state enum and
  the reset status record layout.
  Assumes a single 25 MHz system clock and synchronous active-high reset.
*/
package rpq_pkg;

  // Timing counts in system clock cycles
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned QUAL_CYCLES     = 10;   // Low time before reset starts
  localparam int unsigned GLITCH_CYCLES   = 2;    // Spikes longer than this flagged
  localparam int unsigned OUT_DELAY       = 3;    // Start-to-pin-assert delay
  localparam int unsigned HOLD_CYCLES     = 32;   // HOLD state length, output pin low
  localparam int unsigned WKP_LEAD        = 4;    // Sample this long before release
  localparam int unsigned CNT_W           = 8;

  localparam logic [7:0] CNT_ZERO = 8'h00;

  // Reset status record reset values
  localparam logic RSR_WKP_RST  = 1'b0;
  localparam logic RSR_BOOT_RST = 1'b0;

  typedef enum logic [1:0] {
    RPQ_IDLE  = 2'b00,
    RPQ_DELAY = 2'b01,
    RPQ_HOLD  = 2'b11,
    RPQ_DONE  = 2'b10
  } rpq_state_e;

  typedef struct packed {
    logic ext_reset;   // Last reset came from the pin
    logic int_reset;   // Last reset came from an internal source
    logic glitch;      // Glitch seen on the reset pin
    logic weak_pull;   // Weak-pull config sampled
    logic boot_mode;   // Boot config sampled
  } rpq_status_s;

endpackage : rpq_pkg

// ---- rtl/rpq_sync.sv ----
/*
  Two-flop synchroniser for the asynchronous pins.
  Assumes inputs come from pads outside the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module rpq_sync #(
  parameter int unsigned WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // First stage only feeds the second
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta   <= INIT;
      sync_o <= INIT;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : rpq_sync
`default_nettype wire

// ---- rtl/rpq_top.sv ----
/*
  Reset pin qualifier: filters the active-low reset pin, flags glitches,
  sequences the internal reset and drives the active-low reset output pin.
  Assumes one system clock; pins are asynchronous and get synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
module rpq_top #(
  parameter int unsigned QUAL_CYCLES = rpq_pkg::QUAL_CYCLES,
  parameter int unsigned OUT_DELAY   = rpq_pkg::OUT_DELAY,
  parameter int unsigned HOLD_CYCLES = rpq_pkg::HOLD_CYCLES
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic         reset_pin_n_i,
  input  wire logic         int_reset_req_i,
  input  wire logic         weak_pull_config_pin_i,
  input  wire logic         boot_config_pin_i,
  output logic              reset_output_pin_n_o,
  output logic              int_reset_o,
  output rpq_pkg::rpq_status_s reset_status_record_o
);

  logic [2:0] pins_sync;
  logic       pin_n;
  logic       wkp_s;
  logic       boot_s;

  // Pins are asynchronous to sys_clk_i
  rpq_sync #(
    .WIDTH (3),
    .INIT  (3'h1)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   ({boot_config_pin_i, weak_pull_config_pin_i, reset_pin_n_i}),
    .sync_o    (pins_sync)
  );
  assign pin_n  = pins_sync[0];  // low means request
  assign wkp_s  = pins_sync[1];
  assign boot_s = pins_sync[2];

  // Low-time filter and glitch detector
  logic [7:0] low_cnt, next_low_cnt;
  logic       pin_qual;
  logic       glitch_ev;

  // Glitch floor: a low run must last longer than this many
  // synced cycles before its release counts as a spike.
  // Kept in one place so the threshold can later become a
  // module parameter without touching the detector itself.
  function automatic logic [7:0] glitch_floor();
    return 8'(rpq_pkg::GLITCH_CYCLES);
  endfunction : glitch_floor

  // Low run still short of qualification. Shared by the
  // filter counter, which stops at the limit, and by the
  // glitch detector, which ignores runs that qualified.
  function automatic logic short_run(input logic [7:0] cnt);
    return (cnt < 8'(QUAL_CYCLES));
  endfunction : short_run

  // Hold decode, shared by the sequencer and the status record
  function automatic logic holding(input rpq_pkg::rpq_state_e s);
    return (s == rpq_pkg::RPQ_HOLD);
  endfunction : holding

  // Filter counter: counts synced low cycles and saturates at
  // the qualification count. Saturation means a pin held low
  // for a long time qualifies exactly once; a second request
  // needs the pin to go high and low again.
  // Limitation: the two-flop synchroniser adds two cycles of
  // lag, so the pin-to-qualification time is twelve cycles.
  always_comb begin
    next_low_cnt = rpq_pkg::CNT_ZERO;
    if (!pin_n && short_run(low_cnt)) begin
      next_low_cnt = low_cnt + 8'h01;
    end else if (!pin_n) begin
      next_low_cnt = low_cnt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      low_cnt <= rpq_pkg::CNT_ZERO;
    end else begin
      low_cnt <= next_low_cnt;
    end
  end

  // Qualified once ten consecutive low cycles are seen
  assign pin_qual = !pin_n && (low_cnt == 8'(QUAL_CYCLES - 1));
  // Release after more than two but under ten low cycles
  assign glitch_ev = pin_n && (low_cnt > glitch_floor()) && short_run(low_cnt);

  // Reset sequencer
  rpq_pkg::rpq_state_e state, next_state;
  logic [7:0] seq_cnt, next_seq_cnt;
  logic       start;
  logic       out_n, next_out_n;

  // Sequence per request: DELAY for the output delay count,
  // then HOLD with the output pin low for the hold count,
  // then one DONE cycle before the pin is released.
  // A request in DELAY restarts the delay; a request in HOLD
  // restarts the hold count but keeps the pin low, so the pin
  // never shows a short high pulse between two resets.
  // Trade-off: a request stream faster than the hold count
  // keeps the device in reset indefinitely, which is intended.
  assign start = pin_qual || int_reset_req_i;

  always_comb begin
    next_state   = state;
    next_seq_cnt = seq_cnt;
    next_out_n   = out_n;
    if (start) begin
      // New request restarts the sequence at DELAY, except in HOLD
      next_state   = rpq_pkg::RPQ_DELAY;
      next_seq_cnt = rpq_pkg::CNT_ZERO;
      if (holding(state)) begin
        next_state = rpq_pkg::RPQ_HOLD;  // Output already low, keep it
      end
    end else begin
      unique case (state)
        rpq_pkg::RPQ_IDLE: begin
          next_out_n = 1'b1;
        end
        rpq_pkg::RPQ_DELAY: begin
          next_seq_cnt = seq_cnt + 8'h01;
          if (seq_cnt == 8'(OUT_DELAY - 1)) begin
            next_state   = rpq_pkg::RPQ_HOLD;
            next_seq_cnt = rpq_pkg::CNT_ZERO;
            next_out_n   = 1'b0;
          end
        end
        rpq_pkg::RPQ_HOLD: begin
          next_seq_cnt = seq_cnt + 8'h01;
          if (seq_cnt == 8'(HOLD_CYCLES - 1)) begin
            next_state   = rpq_pkg::RPQ_DONE;
            next_seq_cnt = rpq_pkg::CNT_ZERO;
          end
        end
        rpq_pkg::RPQ_DONE: begin
          next_state = rpq_pkg::RPQ_IDLE;
          next_out_n = 1'b1;
        end
      endcase
    end
  end

  // Device reset itself starts a sequence: output low from reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state   <= rpq_pkg::RPQ_HOLD;
      seq_cnt <= rpq_pkg::CNT_ZERO;
      out_n   <= 1'b0;
    end else begin
      state   <= next_state;
      seq_cnt <= next_seq_cnt;
      out_n   <= next_out_n;
    end
  end

  assign reset_output_pin_n_o = out_n;
  // Internal reset covers DELAY as well, so logic behind it
  // is already held before the output pin falls
  assign int_reset_o          = (state != rpq_pkg::RPQ_IDLE);

  // Status record: source, glitch, sampled configuration pins
  rpq_pkg::rpq_status_s status, next_status;
  logic src_pin, next_src_pin;

  always_comb begin
    next_status  = status;
    next_src_pin = src_pin;
    if (pin_qual) begin
      next_src_pin = 1'b1;
    end else if (int_reset_req_i) begin
      next_src_pin = 1'b0;
    end
    if (glitch_ev) begin
      next_status.glitch = 1'b1;
    end
    if (holding(state) && !start) begin
      // Boot pin tracked in every HOLD cycle without a new request, not in DONE
      next_status.boot_mode = boot_s;
      // Release edge is four edges after this hold count:
      // two more hold counts, the last one, then DONE
      if (seq_cnt == 8'(HOLD_CYCLES - rpq_pkg::WKP_LEAD)) begin
        next_status.weak_pull = wkp_s;
      end
    end
    if (state == rpq_pkg::RPQ_DONE) begin
      next_status.ext_reset = src_pin;
      next_status.int_reset = !src_pin;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status  <= '{ext_reset: 1'b0, int_reset: 1'b0, glitch: 1'b0,
                   weak_pull: rpq_pkg::RSR_WKP_RST,
                   boot_mode: rpq_pkg::RSR_BOOT_RST};
      src_pin <= 1'b0;
    end else begin
      status  <= next_status;
      src_pin <= next_src_pin;
    end
  end

  assign reset_status_record_o = status;

endmodule : rpq_top
`default_nettype wire

// ---- verif/rpq_supervisor.sv ----
/* Board reset source model: pulls the reset pin low for a set count.
   Assumes go_i and len_i change just after the clock edge. */
`timescale 1ns/1ps
`default_nettype none
module rpq_supervisor (
  input  wire logic       sys_clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] len_i,
  output logic            pin_n_o
);
  logic [7:0] left = 8'h00;
  // Push-pull drive, so the idle level is a driven high
  always @(posedge sys_clk_i) begin
    if (go_i) left <= len_i;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  assign pin_n_o = (left == 8'h00);
endmodule : rpq_supervisor
`default_nettype wire

// ---- verif/rpq_top_monitor.sv ----
/* Port checker for the reset qualifier, bound into rpq_top.
   Assumes one clock; raw pin counts, so sync lag only adds margin. */
`timescale 1ns/1ps
`default_nettype none
module rpq_top_monitor #(
  parameter int unsigned QUAL_CYCLES = rpq_pkg::QUAL_CYCLES,
  parameter int unsigned OUT_DELAY   = rpq_pkg::OUT_DELAY,
  parameter int unsigned HOLD_CYCLES = rpq_pkg::HOLD_CYCLES
) (
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  input wire logic                 reset_pin_n_i,
  input wire logic                 int_reset_req_i,
  input wire logic                 weak_pull_config_pin_i,
  input wire logic                 boot_config_pin_i,
  input wire logic                 reset_output_pin_n_o,
  input wire logic                 int_reset_o,
  input wire rpq_pkg::rpq_status_s reset_status_record_o
);
  logic [7:0] low_run; // Raw low samples, saturating
  logic [7:0] since;   // Cycles since last cause
  logic       armed;   // Cause seen, a fall is allowed
  logic       cause;
  assign cause = int_reset_req_i || (low_run == 8'(QUAL_CYCLES));
  // Helper counters
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      low_run <= 8'h00;
      since <= 8'h00;
      armed <= 1'b0;
    end else begin
      low_run <= reset_pin_n_i ? 8'h00 : low_run + {7'h00, low_run != 8'hFF};
      since <= cause ? 8'h00 : since + {7'h00, since != 8'hFF};
      armed <= cause || (armed && reset_output_pin_n_o);
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence late_fall_s;
    reset_output_pin_n_o ##1 reset_output_pin_n_o ##[1:8] !reset_output_pin_n_o;
  endsequence
  sequence spike_end_s;
    $rose(reset_pin_n_i) && low_run > 8'(rpq_pkg::GLITCH_CYCLES) && low_run < 8'(QUAL_CYCLES);
  endsequence
  req_delay_a: assert property (int_reset_req_i && reset_output_pin_n_o |-> late_fall_s)
    else $error("output not delayed");
  pin_qual_a: assert property (low_run == 8'(QUAL_CYCLES + 2) |-> ##[0:8] !reset_output_pin_n_o)
    else $error("no output for pin");
  fall_cause_a: assert property ($fell(reset_output_pin_n_o) |-> armed)
    else $error("output without cause");
  hold_min_a: assert property ($rose(reset_output_pin_n_o) |-> since >= 8'(HOLD_CYCLES))
    else $error("released early");
  hold_max_a: assert property (since == 8'(HOLD_CYCLES + OUT_DELAY + 10) |-> reset_output_pin_n_o)
    else $error("never released");
  glitch_set_a: assert property (spike_end_s |-> ##[0:6] reset_status_record_o.glitch)
    else $error("spike not flagged");
  glitch_keep_a: assert property (reset_status_record_o.glitch |=> reset_status_record_o.glitch)
    else $error("flag lost");
  cfg_take_a: assert property ($rose(reset_output_pin_n_o) |->
    reset_status_record_o.weak_pull == $past(weak_pull_config_pin_i, 7)
    && reset_status_record_o.boot_mode == $past(boot_config_pin_i, 6)) else $error("config not taken");
  busy_flag_a: assert property (!reset_output_pin_n_o |-> int_reset_o)
    else $error("pin low while idle");
endmodule : rpq_top_monitor
bind rpq_top rpq_top_monitor #(.QUAL_CYCLES(QUAL_CYCLES), .OUT_DELAY(OUT_DELAY), .HOLD_CYCLES(HOLD_CYCLES)) u_mon (.*);
`default_nettype wire

// ---- verif/rpq_top_tb.sv ----
/* Self-checking bench for rpq_top with a board reset source model.
   Assumes the checker is bound in; releases are checked off a queue. */
`timescale 1ns/1ps
`default_nettype none
module rpq_top_tb;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, req = 1'b0, wk = 1'b1, bt = 1'b0;
  logic prev = 1'b0;
  logic [7:0] len = 8'h00;
  logic pin_n, out_n;
  rpq_pkg::rpq_status_s st;
  logic [16:0] seed = 17'h14D0D;
  logic [4:0] exp_q[$], msk_q[$];
  int miscompares = 0, cmp_count = 0;
  initial forever #20 clk = ~clk;
  rpq_supervisor sup (.sys_clk_i(clk), .go_i(go), .len_i(len), .pin_n_o(pin_n));
  rpq_top DUT (.sys_clk_i(clk), .rst_i(rst), .reset_pin_n_i(pin_n), .int_reset_req_i(req),
    .weak_pull_config_pin_i(wk), .boot_config_pin_i(bt), .reset_output_pin_n_o(out_n),
    .int_reset_o(), .reset_status_record_o(st));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  task close_out;
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task chk(input string n, input logic [4:0] e, input logic [4:0] s);
    cmp_count++;
    if (e !== s) begin
      miscompares++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task pulse(input logic [7:0] n);
    go <= 1'b1;
    len <= n;
    cyc(1);
    go <= 1'b0;
  endtask : pulse
  task ireq;
    req <= 1'b1;
    cyc(1);
    req <= 1'b0;
  endtask : ireq
  task note(input logic [4:0] e, input logic [4:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
  endtask : note
  // New config levels, set only while idle
  task cfg;
    seed = lfsr(seed);
    wk <= seed[0];
    bt <= seed[1];
  endtask : cfg
  // Each release of the output pin takes the oldest note
  always @(negedge clk) begin
    prev <= out_n;
    if (!rst && out_n && !prev) begin
      if (exp_q.size() == 0) chk("release", 5'h00, 5'h1F);
      else chk("status", exp_q.pop_front(), st & msk_q.pop_front());
    end
  end
  initial begin
    note(5'h02, 5'h03);
    cyc(6);
    rst <= 1'b0;
    cyc(60);
    pulse(8'h02);
    cyc(20);
    chk("glitch", 5'h00, {4'h0, st.glitch});
    pulse(8'h09);
    cyc(20);
    chk("glitch", 5'h01, {4'h0, st.glitch});
    chk("pin", 5'h01, {4'h0, out_n});
    cfg;
    note({3'h5, seed[0], seed[1]}, 5'h17);
    pulse(8'h0C);
    cyc(14);
    pulse(8'h0C);
    cyc(90);
    cfg;
    note({3'h3, seed[0], seed[1]}, 5'h0F);
    ireq;
    cyc(20);
    ireq;
    cyc(90);
    rst <= 1'b1;
    cyc(6);
    rst <= 1'b0;
    note({3'h0, seed[0], seed[1]}, 5'h03);
    cyc(60);
    chk("glitch", 5'h00, {4'h0, st.glitch});
    chk("notes", 5'h00, 5'(exp_q.size()));
    close_out;
  end
  // Run needs about 400 cycles
  initial begin
    #(2000 * 40);
    miscompares++;
    close_out;
  end
endmodule : rpq_top_tb
`default_nettype wire
